// file: core/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

   // ****************************************
   // Serial frame format
   // ****************************************
   localparam int unsigned    FRAME_BITS  = 32;
   localparam logic [5:0]     FRAME_LAST  = 6'h20;
   localparam int unsigned    CMD_HI      = 27;
   localparam int unsigned    CMD_LO      = 24;
   localparam int unsigned    ADDR_HI     = 23;
   localparam int unsigned    ADDR_LO     = 20;
   localparam int unsigned    DATA_HI     = 19;
   localparam int unsigned    DATA_LO     = 4;

   // Commands carried in the frame
   localparam logic [3:0]     CMD_WR_IN   = 4'h0;
   localparam logic [3:0]     CMD_UPD_DAC = 4'h1;
   localparam logic [3:0]     CMD_WR_UPD  = 4'h3;
   localparam logic [3:0]     CMD_PWR     = 4'h4;
   localparam logic [3:0]     CMD_CLRCODE = 4'h5;
   localparam logic [3:0]     CMD_DAISY   = 4'h8;

   // Channel addresses
   localparam logic [3:0]     ADDR_A      = 4'h0;
   localparam logic [3:0]     ADDR_B      = 4'h1;
   localparam logic [3:0]     ADDR_ALL    = 4'hF;

   // ****************************************
   // Output codes
   // ****************************************
   localparam logic [15:0]    CODE_ZERO   = 16'h0000;
   localparam logic [15:0]    CODE_MID    = 16'h8000;
   localparam logic [15:0]    CODE_FULL   = 16'hFFFF;
   localparam logic [1:0]     CLR_ZERO    = 2'h0;
   localparam logic [1:0]     CLR_MID     = 2'h1;
   localparam logic [1:0]     CLR_FULL    = 2'h2;
   localparam logic [1:0]     INIT_CYC    = 2'h3;

   // ****************************************
   // APB register map
   // ****************************************
   localparam logic [7:0]     OFS_CTRL    = 8'h00;
   localparam logic [7:0]     OFS_STATUS  = 8'h04;
   localparam logic [7:0]     OFS_IN_A    = 8'h08;
   localparam logic [7:0]     OFS_IN_B    = 8'h0C;
   localparam logic [7:0]     OFS_DAC_A   = 8'h10;
   localparam logic [7:0]     OFS_DAC_B   = 8'h14;
   localparam logic [7:0]     OFS_LAST    = 8'h18;
   localparam int unsigned    CTRL_SWLOAD = 0;

   // Pins from outside the core clock domain
   typedef struct packed {
      logic sclk;
      logic frame_n;
      logic sdin;
      logic load_n;
      logic clear_n;
      logic lockout_n;
      logic por_mid;
   } pins_t;

   // Codes of both channels
   typedef struct packed {
      logic [15:0] b;
      logic [15:0] a;
   } codes_t;

endpackage

// file: core/dual_dac_serial_control.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module dual_dac_serial_control
   import dac_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   // Serial link pins
   input  wire logic        i_sclk,
   input  wire logic        i_frame_n,
   input  wire logic        i_sdin,
   output logic             o_serial_out,
   // Control pins
   input  wire logic        i_load_outputs_n,
   input  wire logic        i_async_clear_n,
   input  wire logic        i_powerdown_lockout_n,
   input  wire logic        i_por_midscale,
   // Converter side
   output codes_t           o_dac_codes,
   output logic [1:0]       o_powered_down,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   // ****************************************
   // Core state
   // ****************************************
   // All converter-side state kept in one record, registered together
   typedef struct packed {
      logic [31:0] shift;
      logic [5:0]  cnt;
      logic        active;
      logic        serial_out;
      codes_t      in;
      codes_t      dac;
      logic [1:0]  pd;
      logic [1:0]  clr_code;
      logic        daisy;
      logic [31:0] last;
      logic [1:0]  init;
   } core_t;

   pins_t        pin_raw;
   pins_t        meta_q;
   pins_t        sync_q;
   pins_t        prev_q;
   core_t        core_q;
   core_t        core_d;
   logic         soft_load_q;
   logic         soft_load_d;
   logic [31:0]  rdata_q;
   logic [31:0]  rdata_d;
   logic         sclk_fall;
   logic         sclk_rise;
   logic         frame_fall;
   logic         frame_rise;
   logic         clear_fall;
   logic         lockout_fall;
   logic         mapped;
   logic         apb_wr;
   logic         load_req;
   logic [31:0]  status_word;

   // ****************************************
   // Pin synchronisers and edge detection
   // ****************************************
   assign pin_raw = '{sclk: i_sclk, frame_n: i_frame_n, sdin: i_sdin,
                      load_n: i_load_outputs_n, clear_n: i_async_clear_n,
                      lockout_n: i_powerdown_lockout_n, por_mid: i_por_midscale};

   // Two stages, then a third copy for edges
   // Every pin passes two flops before logic reads it; prev_q only feeds edges
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         // Held high in reset, the idle level of every pin, so no edge follows reset
         meta_q <= '{default: 1'b1};
         sync_q <= '{default: 1'b1};
         prev_q <= '{default: 1'b1};
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edges seen on the synchronised pins
   // A pin edge is seen about two core cycles after the pin moves
   assign sclk_fall    = prev_q.sclk & ~sync_q.sclk;
   assign sclk_rise    = ~prev_q.sclk & sync_q.sclk;
   assign frame_fall   = prev_q.frame_n & ~sync_q.frame_n;
   assign frame_rise   = ~prev_q.frame_n & sync_q.frame_n;
   assign clear_fall   = prev_q.clear_n & ~sync_q.clear_n;
   assign lockout_fall = prev_q.lockout_n & ~sync_q.lockout_n;

   // ****************************************
   // Load request and status word
   // ****************************************
   // Load pin is a level: tying it low keeps outputs tracking the inputs;
   // a held clear pin masks it so the load cannot overwrite the clear code
   assign load_req = (~sync_q.load_n | soft_load_q) & sync_q.clear_n;

   // Status word: lockout pin, daisy, frame active, clear code, power-down
   assign status_word = {24'h000000, sync_q.lockout_n, core_q.daisy, core_q.active,
                         core_q.clr_code, core_q.pd, 1'b0};

   // ****************************************
   // Helpers
   // ****************************************
   // Code chosen by the clear-code selection
   function automatic logic [15:0] clr_value(input logic [1:0] sel);
      logic [15:0] v;
      case (sel)
         CLR_MID:  v = CODE_MID;
         CLR_FULL: v = CODE_FULL;
         default:  v = CODE_ZERO;
      endcase
      return v;
   endfunction

   // Carry out one complete command word
   function automatic core_t execute(input core_t c, input logic lock_n);
      core_t      r;
      logic [3:0] cmd;
      logic [3:0] adr;
      logic [15:0] dat;
      logic       sel_a;
      logic       sel_b;
      r     = c;
      // Field split of the received word
      cmd   = c.shift[CMD_HI:CMD_LO];
      adr   = c.shift[ADDR_HI:ADDR_LO];
      dat   = c.shift[DATA_HI:DATA_LO];
      sel_a = (adr == ADDR_A) || (adr == ADDR_ALL);
      sel_b = (adr == ADDR_B) || (adr == ADDR_ALL);
      r.last = c.shift;
      case (cmd)
         CMD_WR_IN, CMD_WR_UPD: begin
            // Input registers always, DAC registers only for the update form
            if (sel_a) begin
               r.in.a = dat;
            end
            if (sel_b) begin
               r.in.b = dat;
            end
            if (cmd == CMD_WR_UPD) begin
               if (sel_a) begin
                  r.dac.a = dat;
               end
               if (sel_b) begin
                  r.dac.b = dat;
               end
            end
         end
         CMD_UPD_DAC: begin
            // Software copy of chosen channels, like the load pin
            if (sel_a) begin
               r.dac.a = c.in.a;
            end
            if (sel_b) begin
               r.dac.b = c.in.b;
            end
         end
         CMD_PWR: begin
            // Entering power-down only while lockout pin is high
            if (lock_n) begin
               r.pd = dat[1:0];
            end else begin
               // With lockout low only bits already set may be cleared
               r.pd = c.pd & dat[1:0];
            end
         end
         CMD_CLRCODE: begin
            // Only the selection moves; outputs change at the next clear
            r.clr_code = dat[1:0];
         end
         CMD_DAISY: begin
            // Daisy mode defers execution to the rise of frame-select
            r.daisy = dat[0];
         end
         default: begin
            // Unknown commands leave every register as it was except last, which takes the word
            r.last = c.shift;
         end
      endcase
      return r;
   endfunction

   // ****************************************
   // Serial frame, registers and outputs
   // ****************************************
   // Next state of the converter control
   // Stages run in order; later ones override earlier ones
   always_comb begin
      core_d = core_q;
      // Power-up level once the strap is synchronised
      // Serial traffic and pin events wait until the strap has passed both stages
      if (core_q.init != INIT_CYC) begin
         core_d.init = core_q.init + 2'h1;
         if (core_d.init == INIT_CYC) begin
            core_d.in.a  = sync_q.por_mid ? CODE_MID : CODE_ZERO;
            core_d.in.b  = core_d.in.a;
            core_d.dac   = core_d.in;
         end
      end else begin
         // Frame start arms the shift register
         if (frame_fall) begin
            core_d.active = 1'b1;
            core_d.cnt    = 6'h00;
         end else if (sync_q.frame_n) begin
            // Frame end: daisy word runs now, short one is dropped
            if (frame_rise && core_q.active) begin
               if (core_q.daisy && core_q.cnt >= FRAME_LAST) begin
                  core_d = execute(core_q, sync_q.lockout_n);
               end
            end
            core_d.active = 1'b0;
         end else if (core_q.active && sclk_fall) begin
            // One bit in at each serial clock fall
            core_d.shift = {core_q.shift[FRAME_BITS-2:0], sync_q.sdin};
            // Count stops at a full word so later daisy clocks keep the newest 32 bits
            if (core_q.cnt != FRAME_LAST) begin
               core_d.cnt = core_q.cnt + 6'h01;
            end
            if (!core_q.daisy && core_d.cnt == FRAME_LAST) begin
               // Standalone word completes at the 32nd fall
               core_d        = execute(core_d, sync_q.lockout_n);
               core_d.active = 1'b0;
            end
         end
         // MSB presented at serial clock rises
         // Only inside a frame, so a deselected link leaves serial_out still
         if (core_q.active && sclk_rise) begin
            core_d.serial_out = core_q.shift[FRAME_BITS-1];
         end
         // Load pin or software load copies both channels
         if (load_req) begin
            core_d.dac = core_d.in;
         end
         // Clear falling edge loads the clear code
         // Runs after the load copy, so clear wins when both act in one cycle
         if (clear_fall) begin
            core_d.in.a  = clr_value(core_d.clr_code);
            core_d.in.b  = core_d.in.a;
            core_d.dac   = core_d.in;
         end
         // Lockout falling edge ends power-down
         // Codes are untouched; only the power-down bits drop
         if (lockout_fall) begin
            core_d.pd = 2'h0;
         end
      end
   end

   // Register core state
   // Reset gives zero codes and no power-down until the strap is read
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         core_q          <= '0;
         core_q.clr_code <= CLR_ZERO;
      end else begin
         core_q <= core_d;
      end
   end

   // Outputs come straight from flip-flops
   assign o_serial_out   = core_q.serial_out;
   assign o_dac_codes    = core_q.dac;
   assign o_powered_down = core_q.pd;

   // ****************************************
   // APB slave
   // ****************************************
   // Decode of mapped offsets
   // Only the seven listed word offsets are mapped
   always_comb begin
      case (paddr)
         OFS_CTRL, OFS_STATUS, OFS_IN_A, OFS_IN_B,
         OFS_DAC_A, OFS_DAC_B, OFS_LAST: mapped = 1'b1;
         default:                         mapped = 1'b0;
      endcase
   end

   // Zero wait states; an unmapped offset raises the error in the access phase
   assign apb_wr  = psel & penable & pwrite & mapped;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = rdata_q;

   // Read data chosen in setup, software load pulse on write
   // Latching in setup keeps the word standing through the access phase;
   // the soft load pulse lasts one cycle and meets the load request next cycle
   always_comb begin
      rdata_d     = rdata_q;
      soft_load_d = 1'b0;
      if (apb_wr && paddr == OFS_CTRL) begin
         soft_load_d = pwdata[CTRL_SWLOAD];
      end
      if (psel && !penable) begin
         case (paddr)
            OFS_STATUS: rdata_d = status_word;
            OFS_IN_A:   rdata_d = {16'h0000, core_q.in.a};
            OFS_IN_B:   rdata_d = {16'h0000, core_q.in.b};
            OFS_DAC_A:  rdata_d = {16'h0000, core_q.dac.a};
            OFS_DAC_B:  rdata_d = {16'h0000, core_q.dac.b};
            OFS_LAST:   rdata_d = core_q.last;
            default:    rdata_d = 32'h00000000;
         endcase
      end
   end

   // Register APB state
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         rdata_q     <= 32'h00000000;
         soft_load_q <= 1'b0;
      end else begin
         rdata_q     <= rdata_d;
         soft_load_q <= soft_load_d;
      end
   end

endmodule // dual_dac_serial_control

// file: verification/dac_ctrl_monitor.sv
`timescale 1ns/1ps
module dac_ctrl_monitor
   import dac_ctrl_pkg::*;
(
   // Clock, reset and serial pins
   input wire logic        i_core_clk,
   input wire logic        i_srst,
   input wire logic        i_sclk,
   input wire logic        i_frame_n,
   input wire logic        o_serial_out,
   // Control pins and converter side
   input wire logic        i_async_clear_n,
   input wire logic        i_powerdown_lockout_n,
   input wire logic        i_por_midscale,
   input wire codes_t      o_dac_codes,
   input wire logic [1:0]  o_powered_down,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   // ****************************************
   // Pin trackers and assertions
   // ****************************************
   logic       sclk_q;
   logic [5:0] falls_q;
   logic [3:0] age_q;
   logic [3:0] clr_low_q;
   // Clock falls inside a frame, age of last clock rise, time clear held low
   always_ff @(posedge i_core_clk) begin
      sclk_q <= i_sclk;
      if (i_srst || i_frame_n) falls_q <= 6'h00;
      else if (sclk_q && !i_sclk && falls_q != 6'h3F) falls_q <= falls_q + 6'h01;
      if (i_srst) age_q <= 4'hF;
      else if (!sclk_q && i_sclk) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
      if (i_srst || i_async_clear_n) clr_low_q <= 4'h0;
      else if (clr_low_q != 4'hF) clr_low_q <= clr_low_q + 4'h1;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   sequence s_lock_low;
      (!i_powerdown_lockout_n) [*8];
   endsequence
   sequence s_clear_code;
      ##[2:8] (o_dac_codes.a == o_dac_codes.b && (o_dac_codes.a == CODE_ZERO ||
               o_dac_codes.a == CODE_MID || o_dac_codes.a == CODE_FULL));
   endsequence
   a_por_level: assert property ($fell(i_srst) |-> ##[2:4]
      (o_dac_codes == (i_por_midscale ? {CODE_MID, CODE_MID} : 32'h0000_0000))) else $error("bad power-up code");
   a_abort_hold: assert property (($rose(i_frame_n) && falls_q != 6'h00 && falls_q < 6'h20)
      |-> $stable(o_dac_codes) [*8]) else $error("aborted frame changed codes");
   a_clear_code: assert property ($fell(i_async_clear_n) |-> s_clear_code)
      else $error("clear did not load a clear code");
   a_clear_blocks: assert property (clr_low_q >= 4'h8 |-> $stable(o_dac_codes))
      else $error("codes moved while clear held low");
   a_lock_refuse: assert property (s_lock_low |-> o_powered_down == 2'b00)
      else $error("power-down while lockout low");
   a_lock_exit: assert property ($fell(i_powerdown_lockout_n) |-> $stable(o_dac_codes) [*6])
      else $error("lockout fall changed codes");
   a_serial_edge: assert property ($changed(o_serial_out) |-> age_q <= 4'hA)
      else $error("serial out moved away from a clock rise");
   a_apb_unmapped: assert property ((psel && penable && paddr > OFS_LAST) |-> (pslverr && prdata == 32'h0))
      else $error("unmapped access not refused");
   a_apb_mapped: assert property ((psel && penable && paddr <= OFS_LAST && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("mapped access refused");
   a_ready_now: assert property ((psel && penable) |-> pready) else $error("access phase stalled");
endmodule // dac_ctrl_monitor

bind dual_dac_serial_control dac_ctrl_monitor dac_ctrl_monitor_i (.i_core_clk, .i_srst, .i_sclk, .i_frame_n,
   .o_serial_out, .i_async_clear_n, .i_powerdown_lockout_n, .i_por_midscale, .o_dac_codes, .o_powered_down,
   .psel, .penable, .paddr, .prdata, .pready, .pslverr);

// file: verification/dual_dac_serial_control_tb.sv
`timescale 1ns/1ps
module dual_dac_serial_control_tb;
   import dac_ctrl_pkg::*;
   // ****************************************
   // Bench signals, clock and instances
   // ****************************************
   logic        i_core_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_sclk, i_frame_n, i_sdin, o_serial_out;
   logic        i_load_outputs_n = 1'b1;
   logic        i_async_clear_n = 1'b1;
   logic        i_powerdown_lockout_n = 1'b1;
   logic        i_por_midscale = 1'b1;
   codes_t      o_dac_codes, seen_q;
   codes_t      exp_q[$];
   logic [1:0]  o_powered_down;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h99A5666F;
   logic [15:0] d1, d2, d3;
   logic [31:0] sdo_cap = 32'h0;
   int          bad_count = 0;
   int          n_checks = 0;
   // 40 MHz core clock
   always #12.5 i_core_clk = ~i_core_clk;
   dual_dac_serial_control dual_dac_serial_control_i (.i_core_clk, .i_srst, .i_sclk, .i_frame_n, .i_sdin,
      .o_serial_out, .i_load_outputs_n, .i_async_clear_n, .i_powerdown_lockout_n, .i_por_midscale,
      .o_dac_codes, .o_powered_down, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   host_serial_model host_serial_model_i (.o_sclk(i_sclk), .o_frame_n(i_frame_n), .o_sdin(i_sdin));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] w(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
      return {4'h0, c, a, d, 4'h0};
   endfunction
   // Random code that is never zero, midscale or full scale
   function automatic logic [15:0] rnd16();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return {1'b0, lfsr[14:1], 1'b1};
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic stuck(input string what);
      bad_count++;
      $display("[ERR] %s expected done seen timeout", what);
      close_out();
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Wait for all noted code changes, then a quiet spell
   task automatic settle();
      for (int n = 0; exp_q.size() != 0; n++) begin
         if (n > 400) stuck("codes");
         @(posedge i_core_clk);
      end
      repeat (10) @(posedge i_core_clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_core_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
      @(posedge i_core_clk);
      penable <= 1'b1;
      for (int n = 0; n == 0 || pready !== 1'b1; n++) begin
         if (n > 50) stuck("apb ready");
         @(posedge i_core_clk);
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic pulse_load();
      @(posedge i_core_clk) i_load_outputs_n <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_load_outputs_n <= 1'b1;
   endtask
   task automatic clear_pin(input logic v);
      @(posedge i_core_clk) i_async_clear_n <= v;
   endtask
   // Each change of the codes retires the oldest noted expectation
   always @(posedge i_core_clk) begin
      if (!i_srst && o_dac_codes !== seen_q) begin
         if (exp_q.size() == 0) chk("codes unexpected", seen_q, o_dac_codes);
         else chk("codes", exp_q.pop_front(), o_dac_codes);
      end
      seen_q <= o_dac_codes;
   end
   // Serial out as the host sees it, sampled at each clock fall in a frame
   always @(negedge i_sclk) begin
      if (!i_frame_n) sdo_cap <= {sdo_cap[30:0], o_serial_out};
   end
   initial begin
      repeat (100000) @(posedge i_core_clk);
      stuck("run limit");
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (4) @(posedge i_core_clk);
      exp_q.push_back({CODE_MID, CODE_MID});
      i_srst <= 1'b0;
      settle();
      $display("test power-up done");
      d1 = rnd16();
      d2 = rnd16();
      d3 = rnd16();
      exp_q.push_back({CODE_MID, d1});
      host_serial_model_i.send(w(CMD_WR_UPD, ADDR_A, d1), 32);
      settle();
      host_serial_model_i.send(w(CMD_WR_UPD, ADDR_B, d3), 20);
      host_serial_model_i.idle_clocks(8);
      host_serial_model_i.send(w(CMD_WR_IN, ADDR_B, d2), 32);
      exp_q.push_back({d2, d1});
      pulse_load();
      settle();
      $display("test write abort load done");
      exp_q.push_back(32'h0);
      clear_pin(1'b0);
      settle();
      host_serial_model_i.send(w(CMD_WR_IN, ADDR_A, d3), 32);
      pulse_load();
      settle();
      clear_pin(1'b1);
      host_serial_model_i.send(w(CMD_CLRCODE, ADDR_ALL, {14'h0, CLR_FULL}), 32);
      exp_q.push_back({CODE_FULL, CODE_FULL});
      clear_pin(1'b0);
      settle();
      clear_pin(1'b1);
      apb(1'b0, OFS_IN_A, 32'h0);
      chk("input A", {16'h0, CODE_FULL}, rd);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      host_serial_model_i.send(w(CMD_WR_IN, ADDR_A, d1), 32);
      exp_q.push_back({CODE_FULL, d1});
      apb(1'b1, OFS_CTRL, 32'h1);
      settle();
      $display("test clear and bus done");
      host_serial_model_i.send(w(CMD_PWR, ADDR_ALL, 16'h0003), 32);
      chk("serial out", w(CMD_WR_IN, ADDR_A, d1) & 32'h7FFFFFFF, sdo_cap & 32'h7FFFFFFF);
      chk("powered down", 32'h3, {30'h0, o_powered_down});
      @(posedge i_core_clk) i_powerdown_lockout_n <= 1'b0;
      settle();
      chk("powered down", 32'h0, {30'h0, o_powered_down});
      host_serial_model_i.send(w(CMD_PWR, ADDR_ALL, 16'h0003), 32);
      chk("powered down", 32'h0, {30'h0, o_powered_down});
      @(posedge i_core_clk) i_powerdown_lockout_n <= 1'b1;
      settle();
      $display("test power-down done");
      host_serial_model_i.send(w(CMD_DAISY, ADDR_ALL, 16'h0001), 32);
      exp_q.push_back({d2, d2});
      host_serial_model_i.send(w(CMD_WR_UPD, ADDR_ALL, d2), 32);
      settle();
      apb(1'b0, OFS_DAC_B, 32'h0);
      chk("DAC B", {16'h0, d2}, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status", {24'h0, 1'b1, 1'b1, 1'b0, CLR_FULL, 2'b00, 1'b0}, rd);
      host_serial_model_i.send(w(CMD_DAISY, ADDR_ALL, 16'h0000), 32);
      host_serial_model_i.send(w(CMD_WR_IN, ADDR_A, d3), 32);
      exp_q.push_back({d2, d3});
      host_serial_model_i.send(w(CMD_UPD_DAC, ADDR_A, 16'h0000), 32);
      settle();
      chk("pending", 32'h0, 32'(exp_q.size()));
      $display("test daisy and readback done");
      close_out();
   end
endmodule // dual_dac_serial_control_tb

// file: verification/host_serial_model.sv
`timescale 1ns/1ps
module host_serial_model (
   // Serial link towards the block
   output logic o_sclk,
   output logic o_frame_n,
   output logic o_sdin
);
   // ****************************************
   // Host side of the serial link
   // ****************************************
   initial begin
      o_sclk = 1'b1;
      o_frame_n = 1'b1;
      o_sdin = 1'b0;
   end
   // Select low, one bit per clock fall MSB first; fewer bits abort the word
   task automatic send(input logic [31:0] word, input int nbits);
      o_frame_n = 1'b0;
      for (int k = 31; k > 31 - nbits; k--) begin
         o_sdin = word[k];
         #100 o_sclk = 1'b0;
         #100 o_sclk = 1'b1;
      end
      #100 o_frame_n = 1'b1;
      o_sdin = ~o_sdin;
      #1000;
   endtask
   // Clock and data wiggle with select high, which the block must ignore
   task automatic idle_clocks(input int n);
      repeat (n) begin
         o_sdin = ~o_sdin;
         #100 o_sclk = 1'b0;
         #100 o_sclk = 1'b1;
      end
      #1000;
   endtask
endmodule // host_serial_model
